/* File: dv/adcsr_top_bench.sv */
// Purpose: Self-checking bench for adcsr_top
// Assumes: bready and rready held high, ce high
// Notes: Result slots are written before they are read
`timescale 1ns/1ps
module adcsr_top_bench;
   logic core_clk = 0, rst_n = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
   logic s_axi_arvalid = 0, s_axi_rready = 1, external_irq_6 = 1, external_irq_7 = 1;
   logic conv_busy = 0, conv_stop = 0, result_valid = 0;
   logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, result_group = 0;
   logic [7:0] p1_pin = 8'h3C, key_input = 8'hFF, p1_latch, p1_dir, key_input_gated;
   logic [7:0] converter_control_0, converter_control_2;
   logic [2:0] result_pin = 0;
   logic [9:0] result_data = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, read_select_control;
   logic rtc_clock_gate_bit, timer_clock_gate_bit, serial_port_clock_gate_bit, converter_clock_gate_bit;
   logic clocked_serial_clock_gate_bit, multimaster_bus_clock_gate_bit, external_irq_6_gated;
   logic external_irq_7_gated, assist_enable_a, assist_enable_b, conversion_start_flag;
   int bad_count = 0, cmp_count = 0;
   adcsr_top dut (.*);
   initial forever #2.5 core_clk = ~core_clk;
   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task conclude;
      $display("Compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : conclude
   // Bounded wait ran out: count it and stop
   task tmo(input int n);
      if (n < 99) return;
      bad_count++;
      conclude;
   endtask : tmo
   // Address and data offered together, each dropped once taken
   task wr(input logic [9:0] i, input logic [31:0] v);
      int n;
      s_axi_awaddr <= {i, 2'h0};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      for (n = 0; n < 99; n++) begin
         @(posedge core_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      tmo(n);
      chk({30'h0, s_axi_bresp}, 32'h0);
   endtask : wr
   task rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er);
      int n;
      s_axi_araddr <= {i, 2'h0};
      s_axi_arvalid <= 1;
      for (n = 0; n < 99; n++) begin
         @(posedge core_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      tmo(n);
      chk(s_axi_rdata, e);
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   endtask : rd
   task t_gate;
      rd(adcsr_pkg::IDX_CLOCK_GATE, 32'h0, 2'h0);
      wr(adcsr_pkg::IDX_CLOCK_GATE, 32'hFF);
      rd(adcsr_pkg::IDX_CLOCK_GATE, 32'h0, 2'h0);
      wr(adcsr_pkg::IDX_PROTECTION, 32'h1);
      wr(adcsr_pkg::IDX_CLOCK_GATE, 32'hFF);
      rd(adcsr_pkg::IDX_CLOCK_GATE, 32'h77, 2'h0);
      chk(converter_clock_gate_bit, 32'h1);
      chk({multimaster_bus_clock_gate_bit, clocked_serial_clock_gate_bit, serial_port_clock_gate_bit}, 32'h7);
      chk({timer_clock_gate_bit, rtc_clock_gate_bit}, 32'h3);
      wr(adcsr_pkg::IDX_CLOCK_GATE, 32'h00);
      chk(converter_clock_gate_bit, 32'h0);
   endtask : t_gate
   task t_port;
      wr(adcsr_pkg::IDX_PORT_CONTROL, 32'hFF);
      rd(adcsr_pkg::IDX_PORT_CONTROL, 32'hE9, 2'h0);
      chk({external_irq_6_gated, key_input_gated}, 32'h0);
      wr(adcsr_pkg::IDX_PORT_CONTROL, 32'h08);
      @(posedge core_clk);
      chk({external_irq_7_gated, key_input_gated}, 32'h10F);
   endtask : t_port
   // Low nibble output, high nibble input
   task t_p1;
      wr(adcsr_pkg::IDX_P1_DIR, 32'h0F);
      wr(adcsr_pkg::IDX_P1_DATA, 32'hA5);
      rd(adcsr_pkg::IDX_P1_DATA, 32'h35, 2'h0);
      wr(adcsr_pkg::IDX_PORT_CONTROL, 32'h01);
      rd(adcsr_pkg::IDX_P1_DATA, 32'hA5, 2'h0);
      chk({p1_dir, p1_latch, 7'h00, read_select_control}, 32'h0FA501);
   endtask : t_p1
   task pr(input logic [1:0] g, input logic [2:0] p, input logic [9:0] v);
      result_group <= g;
      result_pin <= p;
      result_data <= v;
      result_valid <= 1;
      @(posedge core_clk);
      result_valid <= 0;
      @(posedge core_clk);
   endtask : pr
   task t_res;
      pr(2'h0, 3'h2, 10'h155);
      pr(2'h2, 3'h1, 10'h2AA);
      pr(2'h2, 3'h2, 10'h3FF);
      pr(2'h1, 3'h5, 10'h0AA);
      rd(adcsr_pkg::IDX_RESULT_BASE + 10'h4, 32'h155, 2'h0);
      rd(adcsr_pkg::IDX_RESULT_BASE + 10'h2, 32'h2AA, 2'h0);
      rd(adcsr_pkg::IDX_RESULT_BASE + 10'hA, 32'h0AA, 2'h0);
      rd(adcsr_pkg::IDX_RESULT_BASE + 10'h1, 32'h0, 2'h2);
   endtask : t_res
   task t_start;
      wr(adcsr_pkg::IDX_ASSIST, 32'hFF);
      rd(adcsr_pkg::IDX_ASSIST, 32'h30, 2'h0);
      chk({assist_enable_b, assist_enable_a}, 32'h3);
      @(posedge core_clk);
      wr(adcsr_pkg::IDX_CONTROL_0, 32'h40);
      chk(conversion_start_flag, 32'h1);
      conv_stop <= 1;
      @(posedge core_clk);
      conv_stop <= 0;
      @(posedge core_clk);
      chk(conversion_start_flag, 32'h0);
      conv_busy <= 1;
      wr(adcsr_pkg::IDX_CONTROL_2, 32'h5A);
      conv_busy <= 0;
      rd(adcsr_pkg::IDX_STATUS, 32'h1, 2'h0);
      chk({converter_control_2, converter_control_0}, 32'h5A00);
   endtask : t_start
   initial begin
      repeat (16) @(posedge core_clk);
      rst_n <= 1;
      @(posedge core_clk);
      t_gate;
      t_port;
      t_p1;
      t_res;
      t_start;
      conclude;
   end
endmodule : adcsr_top_bench

/* File: dv/adcsr_top_properties.sv */
// Purpose: Port-level checks for adcsr_top
// Assumes: ce held high by the bench
// Notes: Bound to every adcsr_top instance
`timescale 1ns/1ps
module adcsr_properties (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic converter_clock_gate_bit,
   input wire logic conversion_start_flag,
   input wire logic conv_stop,
   input wire logic external_irq_6,
   input wire logic external_irq_6_gated,
   input wire logic external_irq_7,
   input wire logic external_irq_7_gated,
   input wire logic [7:0] key_input,
   input wire logic [7:0] key_input_gated
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // Gate may only move next to a write response, refused or not, so the lock itself goes unchecked
   a_gate_locked: assert property ($changed(converter_clock_gate_bit) |-> s_axi_bvalid || $past(s_axi_bvalid))
      else $error("gate moved without write");
   a_stop_clears: assert property (conv_stop |=> !conversion_start_flag || s_axi_bvalid)
      else $error("flag kept");
   a_irq6_gate: assert property (external_irq_6_gated |-> $past(external_irq_6)) else $error("irq6 leak");
   a_irq7_gate: assert property (external_irq_7_gated |-> $past(external_irq_7)) else $error("irq7 leak");
   a_key_gate: assert property ((key_input_gated & ~$past(key_input)) == 8'h00) else $error("key leak");
   a_read_latency: assert property (s_axi_arvalid && s_axi_arready |-> ##[2:3] s_axi_rvalid) else $error("read late");
   a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write late");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read twice");
endmodule : adcsr_properties
bind adcsr_top adcsr_properties u_props (.*);

/* File: hw/adcsr_axil.sv */
// Purpose: AXI4-Lite slave front end for the register bank
// Assumes: One write and one read under way at a time
// Notes: Write address and data are taken in either order
`timescale 1ns/1ps
module adcsr_axil (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [adcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [adcsr_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [adcsr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [adcsr_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic wr_en,
   output logic [adcsr_pkg::ADDR_W-1:0] wr_addr,
   output logic [adcsr_pkg::DATA_W-1:0] wr_data,
   output logic [3:0] wr_strb,
   input wire logic wr_hit,
   output logic rd_en,
   output logic [adcsr_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [adcsr_pkg::DATA_W-1:0] rd_word,
   input wire logic rd_hit
);
   logic aw_full; // Address held
   logic w_full; // Data held
   logic rd_pend; // Read word settles this cycle
   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;

   // Hold off new writes until the response is gone
   assign s_axi_awready = !aw_full && !s_axi_bvalid;
   assign s_axi_wready = !w_full && !s_axi_bvalid;
   assign wr_en = aw_full && w_full && !s_axi_bvalid;
   // Address accepted only when no read is in flight
   assign s_axi_arready = !rd_pend && !s_axi_rvalid;
   assign rd_en = s_axi_arvalid && s_axi_arready;

   // Write channel capture and response
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         wr_addr <= '0;
         wr_data <= '0;
         wr_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= adcsr_pkg::RESP_OKAY;
      end else if (ce) begin
         if (aw_take) begin
            aw_full <= 1'b1;
            wr_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_full <= 1'b1;
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
         end
         if (wr_en) begin
            // Commit and answer in one step
            aw_full <= 1'b0;
            w_full <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? adcsr_pkg::RESP_OKAY : adcsr_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Read channel: address, one settle cycle, then data
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_pend <= 1'b0;
         rd_addr <= '0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= adcsr_pkg::RESP_OKAY;
      end else if (ce) begin
         rd_pend <= rd_en;
         if (rd_en) begin
            rd_addr <= s_axi_araddr;
         end
         if (rd_pend) begin
            // Memory data is registered, so sample it a cycle late
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_hit ? rd_word : '0;
            s_axi_rresp <= rd_hit ? adcsr_pkg::RESP_OKAY : adcsr_pkg::RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule : adcsr_axil

/* File: hw/adcsr_result_mem.sv */
// Purpose: Eight-slot conversion result store
// Assumes: One write and one read port, registered read data
// Notes: Array has no reset; contents are undefined until written
`timescale 1ns/1ps
module adcsr_result_mem (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic wr_en,
   input wire logic [adcsr_pkg::SLOT_W-1:0] wr_slot,
   input wire logic [adcsr_pkg::RESULT_REG_W-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [adcsr_pkg::SLOT_W-1:0] rd_slot,
   output logic [adcsr_pkg::RESULT_REG_W-1:0] rd_data
);
   // Storage array, left unreset to stay a plain memory
   logic [adcsr_pkg::RESULT_REG_W-1:0] mem [adcsr_pkg::SLOTS];

   // Write port
   always_ff @(posedge core_clk) begin
      if (ce && wr_en) begin
         mem[wr_slot] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (ce && rd_en) begin
         rd_data <= mem[rd_slot];
      end
   end
endmodule : adcsr_result_mem

/* File: hw/adcsr_top.sv */
// Purpose: Converter support registers: clock gating, port control, assist, results
// Assumes: Conversion engine, trigger and divider live outside this block
// Notes: Registers reached over AXI4-Lite, one aligned word per register
// Operation
// - Gate bit 0 supplies f1, 1 stops
// - Gate bits b3, b7 unstored, write zero
// - Port read: pins/latch, or latch only
// - Key and irq enables: 0 on, 1 off
// - Port control b2-b1, b4 unstored
// - Pin i of any group fills slot i
// - Control 2 write mid-conversion spoils result
// - Start flag: write 1 starts, 0 stops
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
module adcsr_top (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [adcsr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [adcsr_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [adcsr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [adcsr_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic rtc_clock_gate_bit,
   output logic timer_clock_gate_bit,
   output logic serial_port_clock_gate_bit,
   output logic converter_clock_gate_bit,
   output logic clocked_serial_clock_gate_bit,
   output logic multimaster_bus_clock_gate_bit,
   output logic read_select_control,
   input wire logic [7:0] p1_pin,
   output logic [7:0] p1_latch,
   output logic [7:0] p1_dir,
   input wire logic [adcsr_pkg::KEYS-1:0] key_input,
   input wire logic external_irq_6,
   input wire logic external_irq_7,
   output logic [adcsr_pkg::KEYS-1:0] key_input_gated,
   output logic external_irq_6_gated,
   output logic external_irq_7_gated,
   output logic assist_enable_a,
   output logic assist_enable_b,
   output logic [7:0] converter_control_0,
   output logic [7:0] converter_control_2,
   output logic conversion_start_flag,
   input wire logic conv_busy,
   input wire logic conv_stop,
   input wire logic result_valid,
   input wire logic [1:0] result_group,
   input wire logic [adcsr_pkg::SLOT_W-1:0] result_pin,
   input wire logic [adcsr_pkg::RESULT_W-1:0] result_data
);
   // Register index match, shared by read and write decode
   function automatic logic idx_is(input logic [adcsr_pkg::ADDR_W-1:0] addr,
                                   input logic [adcsr_pkg::IDX_W-1:0] idx);
      idx_is = (addr[adcsr_pkg::ADDR_W-1:adcsr_pkg::IDX_LSB] == idx);
   endfunction : idx_is

   // Result word match: even index inside the result window only
   function automatic logic idx_result(input logic [adcsr_pkg::ADDR_W-1:0] addr);
      logic [adcsr_pkg::IDX_W-1:0] i;
      i = addr[adcsr_pkg::ADDR_W-1:adcsr_pkg::IDX_LSB];
      idx_result = (i >= adcsr_pkg::IDX_RESULT_BASE) && (i <= adcsr_pkg::IDX_RESULT_LAST) && !i[0];
   endfunction : idx_result

   // Bus side wires
   logic wr_en; // Write commit pulse
   logic [adcsr_pkg::ADDR_W-1:0] wr_addr; // Held write address
   logic [adcsr_pkg::DATA_W-1:0] wr_data; // Held write data
   logic [3:0] wr_strb; // Held byte enables
   logic wr_hit; // Write lands on a mapped register
   logic rd_en; // Read address taken
   logic [adcsr_pkg::ADDR_W-1:0] rd_addr; // Held read address
   logic [adcsr_pkg::DATA_W-1:0] rd_word; // Read mux output
   logic rd_hit; // Read lands on a mapped register
   logic [adcsr_pkg::RESULT_REG_W-1:0] mem_rd; // Registered result word

   // Stored registers
   logic [7:0] clock_gate; // Peripheral clock gating
   logic [7:0] port_control; // Port read and input enables
   logic [7:0] open_circuit_assist; // Assist enables
   logic [7:0] protection; // Write protection
   logic status_c2_spoiled; // Control 2 written mid-conversion

   // Byte write only when lane 0 is enabled
   wire lane0 = wr_en && wr_strb[0];
   wire [7:0] wbyte = wr_data[7:0];

   // Write decode per register
   wire w_gate = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_CLOCK_GATE);
   wire w_pcr = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_PORT_CONTROL);
   wire w_assist = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_ASSIST);
   wire w_prot = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_PROTECTION);
   wire w_p1d = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_P1_DATA);
   wire w_p1r = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_P1_DIR);
   wire w_c0 = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_CONTROL_0);
   wire w_c2 = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_CONTROL_2);
   wire w_stat = lane0 && idx_is(wr_addr, adcsr_pkg::IDX_STATUS);

   // Gate write allowed only with protect bit set
   wire gate_unlocked = protection[adcsr_pkg::PROTECT_POS];

   // Results are read-only but writes to them still answer OKAY
   assign wr_hit = idx_is(wr_addr, adcsr_pkg::IDX_CLOCK_GATE) || idx_is(wr_addr, adcsr_pkg::IDX_PORT_CONTROL)
                   || idx_is(wr_addr, adcsr_pkg::IDX_ASSIST) || idx_is(wr_addr, adcsr_pkg::IDX_PROTECTION)
                   || idx_is(wr_addr, adcsr_pkg::IDX_P1_DATA) || idx_is(wr_addr, adcsr_pkg::IDX_P1_DIR)
                   || idx_is(wr_addr, adcsr_pkg::IDX_CONTROL_0) || idx_is(wr_addr, adcsr_pkg::IDX_CONTROL_2)
                   || idx_is(wr_addr, adcsr_pkg::IDX_STATUS) || idx_result(wr_addr);

   // Bus slave
   adcsr_axil u_axil (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .wr_strb(wr_strb),
      .wr_hit(wr_hit),
      .rd_en(rd_en),
      .rd_addr(rd_addr),
      .rd_word(rd_word),
      .rd_hit(rd_hit)
   );

   // Result slot from pin: same index in every group, extended has two pins
   wire res_ok = result_valid && ((result_group == adcsr_pkg::GROUP_PRIMARY)
                 || (result_group == adcsr_pkg::GROUP_ALTERNATE)
                 || ((result_group == adcsr_pkg::GROUP_EXTENDED) && (result_pin <= adcsr_pkg::EXT_PIN_LAST)));
   wire [adcsr_pkg::RESULT_REG_W-1:0] res_word = {{(adcsr_pkg::RESULT_REG_W - adcsr_pkg::RESULT_W){1'b0}},
                                                  result_data};
   // Memory read slot straight from the incoming address
   wire [adcsr_pkg::SLOT_W-1:0] rd_slot = s_axi_araddr[adcsr_pkg::IDX_LSB+adcsr_pkg::SLOT_W:adcsr_pkg::IDX_LSB+1];

   // Result store, one whole 16-bit word per slot
   adcsr_result_mem u_mem (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .ce(ce),
      .wr_en(res_ok),
      .wr_slot(result_pin),
      .wr_data(res_word),
      .rd_en(rd_en),
      .rd_slot(rd_slot),
      .rd_data(mem_rd)
   );

   // Clock gating register, unstored bits never kept
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         clock_gate <= adcsr_pkg::REG_RESET;
      end else if (ce && w_gate && gate_unlocked) begin
         clock_gate <= wbyte & adcsr_pkg::CLOCK_GATE_MASK;
      end
   end

   // Protection register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         protection <= adcsr_pkg::REG_RESET;
      end else if (ce && w_prot) begin
         protection <= wbyte & adcsr_pkg::PROTECT_MASK;
      end
   end

   // Port control register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         port_control <= adcsr_pkg::REG_RESET;
      end else if (ce && w_pcr) begin
         port_control <= wbyte & adcsr_pkg::PORT_CONTROL_MASK;
      end
   end

   // Assist register; software waits a converter clock before starting
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         open_circuit_assist <= adcsr_pkg::REG_RESET;
      end else if (ce && w_assist) begin
         open_circuit_assist <= wbyte & adcsr_pkg::ASSIST_MASK;
      end
   end

   // Port P1 latch and direction
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         p1_latch <= adcsr_pkg::REG_RESET;
         p1_dir <= adcsr_pkg::REG_RESET;
      end else if (ce) begin
         if (w_p1d) begin
            p1_latch <= wbyte;
         end
         if (w_p1r) begin
            p1_dir <= wbyte;
         end
      end
   end

   // Control 0 with start flag; software write beats engine stop
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         converter_control_0 <= adcsr_pkg::REG_RESET;
      end else if (ce) begin
         if (w_c0) begin
            converter_control_0 <= wbyte;
         end else if (conv_stop) begin
            converter_control_0[adcsr_pkg::START_FLAG_POS] <= 1'b0;
         end
      end
   end

   // Control 2 store; its fields belong to the engine
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         converter_control_2 <= adcsr_pkg::REG_RESET;
      end else if (ce && w_c2) begin
         converter_control_2 <= wbyte;
      end
   end

   // Spoiled-result flag; a new spoil wins over a clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_c2_spoiled <= 1'b0;
      end else if (ce) begin
         if (w_c2 && conv_busy) begin
            status_c2_spoiled <= 1'b1;
         end else if (w_stat && wbyte[adcsr_pkg::STATUS_C2_POS]) begin
            status_c2_spoiled <= 1'b0;
         end
      end
   end

   // Input gating: enable bit 0 passes, 1 blocks
   // Analog use needs the key group blocked first; software's duty
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         key_input_gated <= '0;
         external_irq_6_gated <= 1'b0;
         external_irq_7_gated <= 1'b0;
      end else if (ce) begin
         key_input_gated[adcsr_pkg::KEY_HALF-1:0] <= key_input[adcsr_pkg::KEY_HALF-1:0]
            & {adcsr_pkg::KEY_HALF{!port_control[adcsr_pkg::KEY_LOW_POS]}};
         key_input_gated[adcsr_pkg::KEYS-1:adcsr_pkg::KEY_HALF] <= key_input[adcsr_pkg::KEYS-1:adcsr_pkg::KEY_HALF]
            & {adcsr_pkg::KEY_HALF{!port_control[adcsr_pkg::KEY_HIGH_POS]}};
         external_irq_6_gated <= external_irq_6 && !port_control[adcsr_pkg::IRQ6_POS];
         external_irq_7_gated <= external_irq_7 && !port_control[adcsr_pkg::IRQ7_POS];
      end
   end

   // Gate outputs straight from flops; 1 withholds f1
   assign rtc_clock_gate_bit = clock_gate[adcsr_pkg::RTC_GATE_POS];
   assign timer_clock_gate_bit = clock_gate[adcsr_pkg::TIMER_GATE_POS];
   assign serial_port_clock_gate_bit = clock_gate[adcsr_pkg::SERIAL_GATE_POS];
   assign converter_clock_gate_bit = clock_gate[adcsr_pkg::CONV_GATE_POS];
   assign clocked_serial_clock_gate_bit = clock_gate[adcsr_pkg::CSIO_GATE_POS];
   assign multimaster_bus_clock_gate_bit = clock_gate[adcsr_pkg::I2C_GATE_POS];
   assign read_select_control = port_control[adcsr_pkg::READ_SEL_POS];
   assign assist_enable_a = open_circuit_assist[adcsr_pkg::ASSIST_A_POS];
   assign assist_enable_b = open_circuit_assist[adcsr_pkg::ASSIST_B_POS];
   assign conversion_start_flag = converter_control_0[adcsr_pkg::START_FLAG_POS];

   // Port read: inputs show pins unless latch-only read is selected
   wire [7:0] p1_read = read_select_control ? p1_latch
                        : ((p1_dir & p1_latch) | (~p1_dir & p1_pin));

   // Read hits, from the held read address
   wire r_gate = idx_is(rd_addr, adcsr_pkg::IDX_CLOCK_GATE);
   wire r_pcr = idx_is(rd_addr, adcsr_pkg::IDX_PORT_CONTROL);
   wire r_assist = idx_is(rd_addr, adcsr_pkg::IDX_ASSIST);
   wire r_prot = idx_is(rd_addr, adcsr_pkg::IDX_PROTECTION);
   wire r_p1d = idx_is(rd_addr, adcsr_pkg::IDX_P1_DATA);
   wire r_p1r = idx_is(rd_addr, adcsr_pkg::IDX_P1_DIR);
   wire r_c0 = idx_is(rd_addr, adcsr_pkg::IDX_CONTROL_0);
   wire r_c2 = idx_is(rd_addr, adcsr_pkg::IDX_CONTROL_2);
   wire r_stat = idx_is(rd_addr, adcsr_pkg::IDX_STATUS);
   // Odd result indices are the high byte halves: refused, whole word only
   wire r_res = idx_result(rd_addr);

   assign rd_hit = r_gate || r_pcr || r_assist || r_prot || r_p1d || r_p1r || r_c0 || r_c2 || r_stat || r_res;

   // Read byte selection; unstored bits already zero
   wire [7:0] rd_byte = r_gate ? clock_gate
                      : r_pcr ? port_control
                      : r_assist ? open_circuit_assist
                      : r_prot ? protection
                      : r_p1d ? p1_read
                      : r_p1r ? p1_dir
                      : r_c0 ? converter_control_0
                      : r_c2 ? converter_control_2
                      : r_stat ? {7'h00, status_c2_spoiled}
                      : 8'h00;

   // Upper bits zero; results give all 16 bits in one word
   assign rd_word = r_res ? {16'h0000, mem_rd} : {24'h000000, rd_byte};
endmodule : adcsr_top

/* File: shared/adcsr_pkg.sv */
// Purpose: Constants for the converter support register bank
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: Registers are 8 bits in the low lane except results (16 bits)
package adcsr_pkg;
   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int IDX_W = 10;
   localparam int IDX_LSB = 2;
   // Register indices (byte address = index * 4)
   localparam logic [IDX_W-1:0] IDX_CLOCK_GATE = 10'h016;
   localparam logic [IDX_W-1:0] IDX_PORT_CONTROL = 10'h366;
   localparam logic [IDX_W-1:0] IDX_ASSIST = 10'h3A2;
   localparam logic [IDX_W-1:0] IDX_RESULT_BASE = 10'h3C0;
   localparam logic [IDX_W-1:0] IDX_RESULT_LAST = 10'h3CE;
   localparam logic [IDX_W-1:0] IDX_CONTROL_2 = 10'h3D4;
   localparam logic [IDX_W-1:0] IDX_CONTROL_0 = 10'h3D6;
   localparam logic [IDX_W-1:0] IDX_PROTECTION = 10'h00A;
   localparam logic [IDX_W-1:0] IDX_P1_DATA = 10'h0E1;
   localparam logic [IDX_W-1:0] IDX_P1_DIR = 10'h0E3;
   localparam logic [IDX_W-1:0] IDX_STATUS = 10'h3D8;
   // Stored bit masks (unstored bits read zero)
   localparam logic [7:0] CLOCK_GATE_MASK = 8'h77;
   localparam logic [7:0] PORT_CONTROL_MASK = 8'hE9;
   localparam logic [7:0] ASSIST_MASK = 8'h30;
   localparam logic [7:0] PROTECT_MASK = 8'h01;
   // Reset values
   localparam logic [7:0] REG_RESET = 8'h00;
   // Field positions
   localparam int RTC_GATE_POS = 0;
   localparam int TIMER_GATE_POS = 1;
   localparam int SERIAL_GATE_POS = 2;
   localparam int CONV_GATE_POS = 4;
   localparam int CSIO_GATE_POS = 5;
   localparam int I2C_GATE_POS = 6;
   localparam int READ_SEL_POS = 0;
   localparam int KEY_HIGH_POS = 3;
   localparam int IRQ6_POS = 5;
   localparam int IRQ7_POS = 6;
   localparam int KEY_LOW_POS = 7;
   localparam int ASSIST_A_POS = 4;
   localparam int ASSIST_B_POS = 5;
   localparam int START_FLAG_POS = 6;
   localparam int PROTECT_POS = 0;
   localparam int STATUS_C2_POS = 0;
   // Result storage
   localparam int RESULT_W = 10;
   localparam int RESULT_REG_W = 16;
   localparam int SLOT_W = 3;
   localparam int SLOTS = 8;
   localparam int KEYS = 8;
   localparam int KEY_HALF = 4;
   // Analog pin groups reported by the conversion engine
   localparam logic [1:0] GROUP_PRIMARY = 2'h0;
   localparam logic [1:0] GROUP_ALTERNATE = 2'h1;
   localparam logic [1:0] GROUP_EXTENDED = 2'h2;
   localparam logic [SLOT_W-1:0] EXT_PIN_LAST = 3'h1;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : adcsr_pkg
